// *** logic/tile_detect_pkg.sv ***
// Purpose: constants shared by the tiled-space and tile-entry detection logic
// Assumes: one core clock, registers reached over a simple word-wide mmio port
// Notes: register indices are word offsets inside the block's mmio window
package tile_detect_pkg;
    localparam int ADDR_W = 48;
    localparam int REG_IDX_W = 2;
    localparam logic [REG_IDX_W-1:0] NULL_MATCH_IDX = 2'h0;
    localparam logic [REG_IDX_W-1:0] INVALID_MATCH_IDX = 2'h1;
    localparam logic [REG_IDX_W-1:0] DETECT_REG_IDX = 2'h2;
    localparam logic [31:0] NULL_MATCH_RESET = 32'h00000000;
    localparam logic [31:0] INVALID_MATCH_RESET = 32'h00000000;
    localparam logic [3:0] MASK_RESET = 4'h0;
    localparam logic [3:0] DATA_RESET = 4'h0;
    localparam int MASK_LSB = 4;
    localparam int DATA_LSB = 0;
    localparam int SPACE_ADDR_LSB = 44;
    localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
    typedef enum logic [1:0] {
        CLASS_RESIDENT = 2'h0,
        CLASS_NULL = 2'h1,
        CLASS_INVALID = 2'h3
    } tile_class_t;
endpackage : tile_detect_pkg

// *** logic/tiled_va_tile_detect.sv ***
// Purpose: tiled-space address hit and null/invalid tile classification of table entries
// Assumes: mmio port and request inputs come from logic on CLK_I
// Notes: results are registered, one cycle after the request
// Notes on behaviour
// (RQ1) Each leaf entry is compared against the programmed 32-bit null match value.
// (RQ2) A null match marks the entry and the whole range it maps as a null tile.
// (RQ3) Entries are also compared against a separate 32-bit invalid match value.
// (RQ4) Mask bits 7:4 of the detect register pick which address bits 47:44 are compared.
// (RQ5) An address bit under a zero mask bit is a don't-care.
// (RQ6) The mask resets to zero, which disables tiled-space detection.
// (RQ7) Software only uses mask 0000 (off) or 1111 (44-bit tiled space).
// (RQ8) Data bits 3:0 are compared with address bits 47:44 at unmasked positions.
// (RQ9) Value compares apply to leaf entries; upper levels carry the flags inline.
// (RQ10) Any null or invalid finding ends the walk and classifies the access.
// (RQ11) The hit is raised only when enabled and every unmasked bit matches its data bit.
`timescale 1ns/1ps
module tiled_va_tile_detect
    import tile_detect_pkg::*;
(
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // mmio register port
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [REG_IDX_W-1:0] REG_IDX_I,
    input wire logic [31:0] REG_WDATA_I,
    output logic [31:0] REG_RDATA_O,
    output logic REG_RVALID_O,
    // memory request address
    input wire logic ADDR_VALID_I,
    input wire logic [ADDR_W-1:0] ADDR_I,
    output logic SPACE_VALID_O,
    output logic SPACE_HIT_O,
    // table entry from the walker
    input wire logic ENTRY_VALID_I,
    input wire logic ENTRY_LEAF_I,
    input wire logic [31:0] ENTRY_I,
    input wire logic UPPER_NULL_I,
    input wire logic UPPER_INVALID_I,
    output logic ENTRY_VALID_O,
    output logic ENTRY_NULL_O,
    output logic ENTRY_INVALID_O,
    output logic WALK_DONE_O
);
    // programmed match values and detect fields
    logic [31:0] null_match;
    logic [31:0] next_null_match;
    logic [31:0] invalid_match;
    logic [31:0] next_invalid_match;
    logic [3:0] space_mask;
    logic [3:0] next_space_mask;
    logic [3:0] space_data;
    logic [3:0] next_space_data;

    // write decode, kept apart so each register group reads a single strobe
    logic wr_null;
    logic wr_invalid;
    logic wr_detect;

    always_comb begin
        wr_null = 1'b0;
        wr_invalid = 1'b0;
        wr_detect = 1'b0;
        if (REG_WR_I) begin
            case (REG_IDX_I)
                NULL_MATCH_IDX: begin
                    wr_null = 1'b1;
                end
                INVALID_MATCH_IDX: begin
                    wr_invalid = 1'b1;
                end
                DETECT_REG_IDX: begin
                    wr_detect = 1'b1;
                end
                default: begin
                    // the fourth word is unmapped; writes to it are dropped
                    wr_null = 1'b0;
                end
            endcase
        end
    end

    // match value registers
    always_comb begin
        next_null_match = null_match;
        next_invalid_match = invalid_match;
        if (wr_null) begin
            next_null_match = REG_WDATA_I; // see (RQ1)
        end
        if (wr_invalid) begin
            next_invalid_match = REG_WDATA_I; // see (RQ3)
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            null_match <= NULL_MATCH_RESET;
            invalid_match <= INVALID_MATCH_RESET;
        end else begin
            null_match <= next_null_match;
            invalid_match <= next_invalid_match;
        end
    end

    // detect register; bits 31:8 are not stored and read back as zero
    always_comb begin
        next_space_mask = space_mask;
        next_space_data = space_data;
        if (wr_detect) begin
            next_space_mask = REG_WDATA_I[MASK_LSB +: 4]; // see (RQ4)
            next_space_data = REG_WDATA_I[DATA_LSB +: 4]; // see (RQ8)
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            space_mask <= MASK_RESET; // see (RQ6)
            space_data <= DATA_RESET;
        end else begin
            space_mask <= next_space_mask;
            space_data <= next_space_data;
        end
    end

    // read port; a read in the same cycle as a write returns the old value
    logic [31:0] next_rdata;
    logic next_rvalid;

    always_comb begin
        next_rvalid = REG_RD_I;
        next_rdata = UNMAPPED_READ;
        if (REG_RD_I) begin
            case (REG_IDX_I)
                NULL_MATCH_IDX: begin
                    next_rdata = null_match;
                end
                INVALID_MATCH_IDX: begin
                    next_rdata = invalid_match;
                end
                DETECT_REG_IDX: begin
                    next_rdata = {24'h000000, space_mask, space_data};
                end
                default: begin
                    next_rdata = UNMAPPED_READ;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            REG_RDATA_O <= UNMAPPED_READ;
            REG_RVALID_O <= 1'b0;
        end else begin
            REG_RDATA_O <= next_rdata;
            REG_RVALID_O <= next_rvalid;
        end
    end

    // address classification; partial masks are honoured bit by bit even though
    // software is expected to use only all-zero or all-one masks (see (RQ7))
    logic [3:0] bit_ok;
    logic next_space_valid;
    logic next_space_hit;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_bit
            // a cleared mask bit forces agreement
            assign bit_ok[gi] = !space_mask[gi] ||
                (ADDR_I[SPACE_ADDR_LSB + gi] == space_data[gi]); // see (RQ5) see (RQ8)
        end
    endgenerate

    always_comb begin
        next_space_valid = ADDR_VALID_I;
        next_space_hit = 1'b0;
        // a zero mask means detection is off, not an always-hit
        if (ADDR_VALID_I && (space_mask != 4'h0)) begin // see (RQ6)
            next_space_hit = &bit_ok; // see (RQ11)
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            SPACE_VALID_O <= 1'b0;
            SPACE_HIT_O <= 1'b0;
        end else begin
            SPACE_VALID_O <= next_space_valid;
            SPACE_HIT_O <= next_space_hit;
        end
    end

    // entry classification
    tile_class_t next_class;
    logic next_entry_valid;
    logic next_entry_null;
    logic next_entry_invalid;
    logic next_walk_done;

    always_comb begin
        next_class = CLASS_RESIDENT;
        if (ENTRY_VALID_I) begin
            if (ENTRY_LEAF_I) begin // see (RQ9)
                // null is checked first; software keeps the two values distinct
                if (ENTRY_I == null_match) begin // see (RQ1)
                    next_class = CLASS_NULL;
                end else if (ENTRY_I == invalid_match) begin // see (RQ3)
                    next_class = CLASS_INVALID;
                end
            end else begin
                if (UPPER_NULL_I) begin // see (RQ9)
                    next_class = CLASS_NULL;
                end else if (UPPER_INVALID_I) begin
                    next_class = CLASS_INVALID;
                end
            end
        end
        next_entry_valid = ENTRY_VALID_I;
        // the flag covers the entry and the whole range behind it
        next_entry_null = (next_class == CLASS_NULL); // see (RQ2)
        next_entry_invalid = (next_class == CLASS_INVALID);
        // either finding ends the walk; the rest of the tables are not read
        next_walk_done = (next_class != CLASS_RESIDENT); // see (RQ10)
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            ENTRY_VALID_O <= 1'b0;
            ENTRY_NULL_O <= 1'b0;
            ENTRY_INVALID_O <= 1'b0;
            WALK_DONE_O <= 1'b0;
        end else begin
            ENTRY_VALID_O <= next_entry_valid;
            ENTRY_NULL_O <= next_entry_null;
            ENTRY_INVALID_O <= next_entry_invalid;
            WALK_DONE_O <= next_walk_done;
        end
    end
endmodule : tiled_va_tile_detect

// *** verification/tile_detect_monitor.sv ***
// Purpose: port checks. Assumes: one clock. Notes: bound after the module.
`timescale 1ns/1ps
module tile_detect_monitor import tile_detect_pkg::*; (
    input wire logic CLK_I, RST_N_I, REG_WR_I, REG_RD_I, REG_RVALID_O, ADDR_VALID_I,
    input wire logic [1:0] REG_IDX_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic SPACE_VALID_O, SPACE_HIT_O, ENTRY_VALID_I, ENTRY_LEAF_I, UPPER_NULL_I,
    input wire logic UPPER_INVALID_I, ENTRY_NULL_O, ENTRY_INVALID_O, WALK_DONE_O);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    sequence s_off; REG_WR_I && REG_IDX_I == 2'h2 && REG_WDATA_I[7:4] == 4'h0
        ##1 !REG_WR_I && ADDR_VALID_I; endsequence
    sequence s_up; ENTRY_VALID_I && !ENTRY_LEAF_I; endsequence
    property p_rv; REG_RD_I |=> REG_RVALID_O; endproperty
    a_rv: assert property (p_rv) else $error("read");
    property p_sv; ADDR_VALID_I |=> SPACE_VALID_O; endproperty
    a_sv: assert property (p_sv) else $error("space");
    property p_nh; !ADDR_VALID_I |=> !SPACE_VALID_O && !SPACE_HIT_O; endproperty
    a_nh: assert property (p_nh) else $error("idle");
    property p_off; s_off |=> !SPACE_HIT_O; endproperty
    a_off: assert property (p_off) else $error("off");
    property p_un; s_up ##0 UPPER_NULL_I |=> ENTRY_NULL_O && WALK_DONE_O; endproperty
    a_un: assert property (p_un) else $error("null");
    property p_ui; s_up ##0 (!UPPER_NULL_I && UPPER_INVALID_I) |=> ENTRY_INVALID_O; endproperty
    a_ui: assert property (p_ui) else $error("inval");
    property p_dn; WALK_DONE_O == (ENTRY_NULL_O || ENTRY_INVALID_O); endproperty
    a_dn: assert property (p_dn) else $error("done");
    property p_ev; !ENTRY_VALID_I |=> !WALK_DONE_O; endproperty
    a_ev: assert property (p_ev) else $error("walk");
endmodule : tile_detect_monitor
bind tiled_va_tile_detect tile_detect_monitor mon (.*);

// *** verification/walker_model.sv ***
// Purpose: page walker. Assumes: core clock. Notes: mixes match values with noise.
`timescale 1ns/1ps
module walker_model (
    input wire logic CLK_I,
    input wire logic [31:0] nv, iv,
    output logic ENTRY_VALID_I = 0, ENTRY_LEAF_I = 0, UPPER_NULL_I = 0, UPPER_INVALID_I = 0,
    output logic [31:0] ENTRY_I = 0);
    logic [31:0] r;
    integer seed = 32'h6f6d;
    always @(posedge CLK_I) begin
        r = $random(seed);
        ENTRY_VALID_I <= r[0];
        ENTRY_LEAF_I <= r[1];
        UPPER_NULL_I <= r[2];
        UPPER_INVALID_I <= r[3];
        ENTRY_I <= r[5] ? (r[4] ? nv : iv) : $random(seed);
    end
endmodule : walker_model

// *** verification/tiled_va_tile_detect_bench.sv ***
// Purpose: random bench. Assumes: 4 ns clock. Notes: model judged at the falling edge of each of the 400 cycles after reset.
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
    $display("wrong value at %0t: output differs from model", $time); end end
module tiled_va_tile_detect_bench;
    logic CLK_I = 0, RST_N_I = 0, REG_WR_I = 0, REG_RD_I = 0, ADDR_VALID_I = 0, n;
    logic [1:0] REG_IDX_I = 0, xs;
    logic [3:0] xe;
    logic [7:0] det = 0;
    logic [31:0] REG_WDATA_I = 0, nv = 0, iv = 0, r, s;
    logic [32:0] xr;
    logic [47:0] ADDR_I = 0;
    wire ENTRY_VALID_I, ENTRY_LEAF_I, UPPER_NULL_I, UPPER_INVALID_I, REG_RVALID_O, SPACE_VALID_O;
    wire SPACE_HIT_O, ENTRY_VALID_O, ENTRY_NULL_O, ENTRY_INVALID_O, WALK_DONE_O;
    wire [31:0] ENTRY_I, REG_RDATA_O;
    integer seed = 32'h6f6d, failures = 0, checked = 0;
    always #2 CLK_I = ~CLK_I;
    walker_model walker (.*);
    tiled_va_tile_detect DUT (.*);
    task automatic end_sim();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim
    initial begin
        repeat (5) @(posedge CLK_I);
        RST_N_I <= 1;
        repeat (400) begin
            @(posedge CLK_I);
            xr = {1'b1, REG_IDX_I == 2'h0 ? nv : REG_IDX_I == 2'h1 ? iv
                : {24'h0, det & {8{REG_IDX_I == 2'h2}}}} & {33{REG_RD_I}};
            xs = {ADDR_VALID_I, ADDR_VALID_I && det[7:4] != 0
                && ((ADDR_I[47:44] ^ det[3:0]) & det[7:4]) == 0};
            n = ENTRY_VALID_I && (ENTRY_LEAF_I ? ENTRY_I == nv : UPPER_NULL_I);
            xe = {ENTRY_VALID_I, n, ENTRY_VALID_I && !n && (ENTRY_LEAF_I ? ENTRY_I == iv
                : UPPER_INVALID_I), 1'b0};
            xe[0] = xe[2] | xe[1];
            if (REG_WR_I && REG_IDX_I == 2'h0) nv = REG_WDATA_I;
            if (REG_WR_I && REG_IDX_I == 2'h1) iv = REG_WDATA_I;
            if (REG_WR_I && REG_IDX_I == 2'h2) det = REG_WDATA_I[7:0];
            r = $random(seed);
            s = $random(seed);
            REG_WR_I <= r[2:0] == 0;
            REG_RD_I <= r[3];
            REG_IDX_I <= r[5:4];
            ADDR_VALID_I <= r[6];
            REG_WDATA_I <= {s[31:8], {4{r[7]}}, s[3:0]};
            ADDR_I <= {r[8] ? det[3:0] : r[12:9], s, s[11:0]};
            @(negedge CLK_I);
            `CHK({REG_RVALID_O, REG_RDATA_O}, xr)
            `CHK({SPACE_VALID_O, SPACE_HIT_O}, xs)
            `CHK({ENTRY_VALID_O, ENTRY_NULL_O, ENTRY_INVALID_O, WALK_DONE_O}, xe)
        end
        $display("random test done");
        end_sim();
    end
endmodule : tiled_va_tile_detect_bench
